// *** ssm_mem_model.sv ***
/*
 * Model of the attached serial memory chips: counts select cycles per chip
 * and cycles where more than one chip is selected.
 * Assumes selects are sampled on ref_clk_i; fitted chips set by board.
 */
`timescale 1ns/1ps

module ssm_mem_model (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    // Board wiring and select lines
    input  wire logic        four_fitted_i,
    input  wire logic [3:0]  sel_n_i,
    // Observed activity
    output logic [3:0][7:0]  hits_o,
    output logic [7:0]       clash_o
);
    logic [3:0] live;

    // Chips c and d only exist on a four-chip board
    assign live = ~sel_n_i & (four_fitted_i ? 4'hF : 4'h3);

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            hits_o  <= '0;
            clash_o <= 8'h00;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (live[k]) hits_o[k] <= hits_o[k] + 8'h01;
            end
            if ($countones(live) > 1) clash_o <= clash_o + 8'h01;
        end
    end
endmodule : ssm_mem_model

// *** ssm_pin_cfg.sv ***
/*
 * Chip-select outputs, shared pin roles, mode select and power-down state.
 * Assumes the recorder core issues access requests on ref_clk_i and that
 * the count-select straps are static during operation.
 */
//
// Contract
// - Active-low selects, one per memory chip, pick one chip per access.
// - Third pin: select c with four chips, else standby high in power-down.
// - Fourth pin: select d with four chips, else count-select bit 0 input.
// - Mode input low gives stand-alone, high gives host interface mode.
// - Reset low clears all state and enters power-down.
`timescale 1ns/1ps

module ssm_pin_cfg
    import ssm_pkg::*;
(
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rstn_i,
    // Core requests
    input  wire logic                 wake_req_i,
    input  wire logic                 sleep_req_i,
    input  wire logic                 mem_access_i,
    input  wire logic [MEM_IDX_W-1:0] mem_index_i,
    input  wire logic                 ext_clk_used_i,
    // Configuration pins
    input  wire logic                 host_mode_select_i,
    input  wire logic                 mem_count_sel_bit1_i,
    input  wire logic                 mem_count_sel_bit2_i,
    // Dedicated chip selects
    output logic                      mem_select_a_n_o,
    output logic                      mem_select_b_n_o,
    // Shared third pin, output only
    output logic                      mem_select_c_n_o,
    // Shared fourth pin, two-way
    input  wire logic                 mem_select_d_n_i,
    output logic                      mem_select_d_n_o,
    output logic                      mem_select_d_n_oe_o,
    // Oscillator output pin enable
    output logic                      osc_pin_oe_o,
    // Status to core
    output logic                      power_down_o,
    output logic                      host_mode_o,
    output logic                      four_chip_o,
    output logic [2:0]                mem_count_o,
    output logic                      access_refused_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_lvl;

    always_comb begin
        pin_raw               = '0;
        pin_raw[PIN_MODE]     = host_mode_select_i;
        pin_raw[PIN_CNT_BIT1] = mem_count_sel_bit1_i;
        pin_raw[PIN_CNT_BIT2] = mem_count_sel_bit2_i;
        pin_raw[PIN_CNT_BIT0] = mem_select_d_n_i;
    end

    ssm_sync #(
        .WIDTH (PIN_W),
        .RST   (PIN_RST)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (pin_raw),
        .level_o   (pin_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic four_chip_f(input logic b1, input logic b2);
        return b1 & b2;
    endfunction : four_chip_f

    function automatic logic [MEM_CHIPS-1:0] sel_n_f(
        input logic [MEM_IDX_W-1:0] idx
    );
        logic [MEM_CHIPS-1:0] v;
        v      = SEL_N_RST;
        v[idx] = 1'b0;
        return v;
    endfunction : sel_n_f

    ////////////////////////////////////////////////////////////////////////
    // State

    ssm_pwr_e             pwr_q;
    ssm_pwr_e             pwr_d;
    logic [MEM_CHIPS-1:0] sel_n_q;
    logic [MEM_CHIPS-1:0] sel_n_d;
    logic                 mode_q;
    logic                 mode_d;
    logic                 four_q;
    logic                 four_d;
    logic [2:0]           count_q;
    logic [2:0]           count_d;
    logic                 standby_q;
    logic                 standby_d;
    logic                 refused_q;
    logic                 refused_d;
    logic                 idx_ok;

    always_comb begin
        pwr_d     = pwr_q;
        sel_n_d   = SEL_N_RST;
        refused_d = 1'b0;
        mode_d    = pin_lvl[PIN_MODE];
        four_d    = four_chip_f(pin_lvl[PIN_CNT_BIT1],
                                pin_lvl[PIN_CNT_BIT2]);
        count_d   = {pin_lvl[PIN_CNT_BIT2], pin_lvl[PIN_CNT_BIT1],
                     four_q ? 1'b0 : pin_lvl[PIN_CNT_BIT0]};
        idx_ok    = four_q || !mem_index_i[1];
        case (pwr_q)
            PWR_DOWN: begin
                if (wake_req_i) begin
                    pwr_d = PWR_RUN;
                end
            end
            PWR_RUN: begin
                if (sleep_req_i) begin
                    pwr_d = PWR_DOWN;
                end else if (mem_access_i) begin
                    if (idx_ok) begin
                        sel_n_d = sel_n_f(mem_index_i);
                    end else begin
                        refused_d = 1'b1;
                    end
                end
            end
            default: begin
                pwr_d = PWR_DOWN;
            end
        endcase
        standby_d = (pwr_d == PWR_DOWN);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            pwr_q     <= PWR_DOWN;
            sel_n_q   <= SEL_N_RST;
            mode_q    <= 1'b0;
            four_q    <= 1'b0;
            count_q   <= COUNT_RST;
            standby_q <= 1'b1;
            refused_q <= 1'b0;
        end else begin
            pwr_q     <= pwr_d;
            sel_n_q   <= sel_n_d;
            mode_q    <= mode_d;
            four_q    <= four_d;
            count_q   <= count_d;
            standby_q <= standby_d;
            refused_q <= refused_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin roles

    assign mem_select_a_n_o    = sel_n_q[0];
    assign mem_select_b_n_o    = sel_n_q[1];
    assign mem_select_c_n_o    = four_q ? sel_n_q[2] : standby_q;
    assign mem_select_d_n_o    = sel_n_q[3];
    assign mem_select_d_n_oe_o = four_q;
    // Oscillator output undriven with external clock or in power-down
    assign osc_pin_oe_o        = !ext_clk_used_i && (pwr_q == PWR_RUN);
    assign power_down_o        = (pwr_q == PWR_DOWN);
    assign host_mode_o         = mode_q;
    assign four_chip_o         = four_q;
    assign mem_count_o         = count_q;
    assign access_refused_o    = refused_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_one_select: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        $countones(~sel_n_q) <= 1)
        else $error("more than one chip select active");

    chk_select_follows: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        (pwr_q == PWR_RUN && !sleep_req_i && mem_access_i && idx_ok)
        |=> !sel_n_q[$past(mem_index_i)])
        else $error("requested chip not selected");

    chk_standby_role: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        (!four_q && pwr_q == PWR_DOWN) |-> mem_select_c_n_o)
        else $error("standby not high in power-down");

    chk_standby_run: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        $fell(standby_q) |-> $past(wake_req_i) && pwr_q == PWR_RUN)
        else $error("standby dropped without wake");

    chk_shared_dir: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        !four_q |-> !mem_select_d_n_oe_o && sel_n_q[3:2] == 2'b11)
        else $error("fourth pin driven outside four-chip config");

    chk_four_decode: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        (pin_lvl[PIN_CNT_BIT1] && pin_lvl[PIN_CNT_BIT2]) |=> four_q)
        else $error("four-chip config not decoded");

    chk_mode_follow: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i)
        $rose(pin_lvl[PIN_MODE]) |=> host_mode_o)
        else $error("host mode not taken");

    chk_reset_down: assert property (@(posedge ref_clk_i)
        !rstn_i |=> power_down_o && sel_n_q == SEL_N_RST && !four_q)
        else $error("reset did not enter power-down");

    cov_wake: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $fell(power_down_o));
    cov_four_d: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        four_q && !mem_select_d_n_o);
    cov_refused: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        access_refused_o);
    cov_host: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        host_mode_o && !mem_select_a_n_o);

endmodule : ssm_pin_cfg

// *** ssm_pkg.sv ***
/*
 * Shared constants for the storage select and mode configuration block.
 * Assumes a single 20 MHz clock and a synchronous active-low reset.
 */
package ssm_pkg;

    // Clock rate and pin synchroniser depth
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SYNC_STAGES   = 3;

    // Number of attached memory chips and chip index width
    localparam int unsigned MEM_CHIPS     = 4;
    localparam int unsigned MEM_IDX_W     = 2;

    // Bit positions inside the synchronised pin vector
    localparam int unsigned PIN_MODE      = 0;
    localparam int unsigned PIN_CNT_BIT1  = 1;
    localparam int unsigned PIN_CNT_BIT2  = 2;
    localparam int unsigned PIN_CNT_BIT0  = 3;
    localparam int unsigned PIN_W         = 4;

    // Reset values
    localparam logic [PIN_W-1:0]     PIN_RST    = 4'h0;
    localparam logic [MEM_CHIPS-1:0] SEL_N_RST  = 4'hF;
    localparam logic [2:0]           COUNT_RST  = 3'h0;

    // Power state, one-hot
    typedef enum logic [1:0] {
        PWR_DOWN = 2'b01,
        PWR_RUN  = 2'b10
    } ssm_pwr_e;

endpackage : ssm_pkg

// *** ssm_sync.sv ***
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes inputs are asynchronous to ref_clk_i; output changes only
 * once the second and third stages agree.
 */
`timescale 1ns/1ps

module ssm_sync
    import ssm_pkg::*;
#(
    parameter int unsigned          WIDTH = PIN_W,
    parameter logic [WIDTH-1:0]     RST   = '0
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    // Pins and filtered result
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] st1_q;
    logic [WIDTH-1:0] st2_q;
    logic [WIDTH-1:0] st3_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] level_d;

    always_comb begin
        level_d = level_q;
        for (int i = 0; i < int'(WIDTH); i++) begin
            if (st2_q[i] == st3_q[i]) begin
                level_d[i] = st3_q[i];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            st1_q   <= RST;
            st2_q   <= RST;
            st3_q   <= RST;
            level_q <= RST;
        end else begin
            st1_q   <= pin_i;
            st2_q   <= st1_q;
            st3_q   <= st2_q;
            level_q <= level_d;
        end
    end

    assign level_o = level_q;

endmodule : ssm_sync

// *** storage_select_and_mode_config_tb_top.sv ***
/*
 * Self-checking bench for the pin configuration block.
 * Assumes the bench drives inputs at falling edges and straps the fourth
 * pin through a mux on d_oe while the block does not drive it.
 */
`timescale 1ns/1ps

module storage_select_and_mode_config_tb_top;
    import ssm_pkg::*;

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: got %0h want %0h", $time, (g), (e)); end end

    logic ref_clk_i = 1'b0, rstn_i = 1'b0, wake = 1'b0, sleep = 1'b0;
    logic acc = 1'b0, ext = 1'b0, mode = 1'b0, b1 = 1'b0, b2 = 1'b0;
    logic strap0 = 1'b0;
    logic [1:0] idx = 2'h0;
    logic a_n, b_n, c_n, d_n, d_oe, osc_oe, pd, hm, four, refused, d_pin;
    logic [2:0] cnt;
    logic [3:0][7:0] hits;
    logic [7:0] clash;
    int fail_count = 0, compares = 0;

    always #25 ref_clk_i = ~ref_clk_i;
    // System strap shows only while the block leaves the pin alone
    assign d_pin = d_oe ? d_n : strap0;

    ssm_pin_cfg i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .wake_req_i(wake), .sleep_req_i(sleep), .mem_access_i(acc),
        .mem_index_i(idx), .ext_clk_used_i(ext), .host_mode_select_i(mode),
        .mem_count_sel_bit1_i(b1), .mem_count_sel_bit2_i(b2),
        .mem_select_a_n_o(a_n), .mem_select_b_n_o(b_n),
        .mem_select_c_n_o(c_n), .mem_select_d_n_i(d_pin),
        .mem_select_d_n_o(d_n), .mem_select_d_n_oe_o(d_oe),
        .osc_pin_oe_o(osc_oe), .power_down_o(pd), .host_mode_o(hm),
        .four_chip_o(four), .mem_count_o(cnt), .access_refused_o(refused));

    ssm_mem_model i_mem (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .four_fitted_i(b1 & b2),
        .sel_n_i({d_oe ? d_n : 1'b1, c_n, b_n, a_n}),
        .hits_o(hits), .clash_o(clash));

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : tick

    task automatic report_and_stop;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic t_idle;
        `CHK(pd, 1'b1)
        `CHK({a_n, b_n, c_n}, 3'h7)
        `CHK({d_oe, osc_oe, refused}, 3'h0)
    endtask : t_idle

    task automatic t_mode;
        for (int m = 1; m >= 0; m--) begin
            mode = m[0];
            tick(8);
            `CHK(hm, m[0])
        end
    endtask : t_mode

    task automatic t_counts;
        for (int i = 0; i < 8; i++) begin
            {b2, b1, strap0} = i[2:0];
            tick(8);
            `CHK(four, b1 & b2)
            `CHK(d_oe, b1 & b2)
            `CHK(cnt, (b1 & b2) ? 3'h6 : i[2:0])
        end
    endtask : t_counts

    task automatic t_access;
        logic [3:0][7:0] h0;
        int r;
        if (!ext) wake = 1'b1;
        tick(1);
        wake = 1'b0;
        tick(2);
        `CHK(pd, 1'b0)
        `CHK(osc_oe, 1'b1)
        if (!four) `CHK(c_n, 1'b0)
        for (int k = 0; k < 4; k++) begin
            h0 = hits;
            r = 0;
            acc = 1'b1;
            idx = k[1:0];
            tick(1);
            acc = 1'b0;
            // Refusal pulse stands in the cycle right after the request
            if (refused === 1'b1) r++;
            repeat (3) begin
                tick(1);
                if (refused === 1'b1) r++;
            end
            `CHK(hits[k] - h0[k], (k < 2 || four) ? 8'h01 : 8'h00)
            `CHK(r, (k >= 2 && !four) ? 1 : 0)
        end
        `CHK(clash, 8'h00)
        sleep = 1'b1;
        tick(1);
        sleep = 1'b0;
        tick(2);
        `CHK(pd, 1'b1)
        `CHK(osc_oe, 1'b0)
        if (!four) `CHK(c_n, 1'b1)
        h0 = hits;
        acc = 1'b1;
        idx = 2'h0;
        tick(3);
        acc = 1'b0;
        `CHK(hits[0], h0[0])
    endtask : t_access

    task automatic t_ext_clk;
        ext = 1'b1;
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        tick(2);
        // External source feeds oscillator input, output left open
        `CHK(osc_oe, 1'b0)
        rstn_i = 1'b0;
        tick(2);
        rstn_i = 1'b1;
        ext = 1'b0;
        tick(1);
        t_idle();
    endtask : t_ext_clk

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(3000 * 50);
        fail_count++;
        report_and_stop();
    end

    initial begin
        tick(5);
        rstn_i = 1'b1;
        tick(1);
        t_idle();
        t_mode();
        {b2, b1, strap0} = 3'h0;
        tick(8);
        t_access();
        // Second access pass runs in host interface mode
        mode = 1'b1;
        t_counts();
        t_access();
        t_ext_clk();
        report_and_stop();
    end
endmodule : storage_select_and_mode_config_tb_top
